// file: logic/pxa_pkg.sv
package pxa_pkg;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_STKYX  = 8'h04;
  localparam logic [7:0] OFS_STKYY  = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_MK = 8'h14;
  localparam int MULT_NEG_BIT   = 6;
  localparam int ALU_INV_BIT    = 5;
  localparam int ALU_SIGN_BIT   = 4;
  localparam int ALU_CARRY_BIT  = 3;
  localparam int ALU_NEG_BIT    = 2;
  localparam int INV_STICKY_BIT = 2;
  localparam int SAT_BIT        = 0;
  localparam int IRQ_INV_BIT    = 0;
  localparam int IRQ_CARRY_BIT  = 1;
  localparam logic [31:0] STATUS_MASK = 32'h0000_007C;
  localparam logic [31:0] STKY_MASK   = 32'h0000_0004;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_0001;
  localparam logic [31:0] IRQ_MASK    = 32'h0000_0003;
  localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
  localparam logic [31:0] STKY_RST    = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] IRQ_RST     = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int EXP_MSB = 30;
  localparam int EXP_LSB = 23;
  localparam logic [7:0] EXP_ONES    = 8'hFF;
  localparam logic [7:0] FIX_OVF_EXP = 8'h9E;
  typedef enum logic [3:0] {
    OP_ADD   = 4'h0,
    OP_SUB   = 4'h1,
    OP_ADDC  = 4'h2,
    OP_SUBC  = 4'h3,
    OP_PASS  = 4'h4,
    OP_MIN   = 4'h5,
    OP_MAX   = 4'h6,
    OP_COMP  = 4'h7,
    OP_ABS   = 4'h8,
    OP_OP_A  = 4'h9,
    OP_FADD  = 4'hA,
    OP_FSUB  = 4'hB,
    OP_FABS  = 4'hC,
    OP_FMANT = 4'hD,
    OP_FIX   = 4'hE,
    OP_FPASS = 4'hF
  } pxa_op_e;
  typedef enum logic [2:0] {
    R_STATUS = 3'h0,
    R_STKYX  = 3'h1,
    R_STKYY  = 3'h2,
    R_CTRL   = 3'h3,
    R_IRQ_ST = 3'h4,
    R_IRQ_MK = 3'h5,
    R_NONE   = 3'h7
  } pxa_reg_e;
endpackage : pxa_pkg

// file: logic/pxa_alu_if.sv
`timescale 1ns/1ps
interface pxa_alu_if;
  import pxa_pkg::*;
  pxa_op_e     op;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] fres;
  logic        carry_in;
  logic        sat_en;
  logic        is_fixed;
  logic        carry_out;
  logic        negative;
  logic        sign_flag;
  logic        invalid;
  modport eval (input op, opa, opb, fres, carry_in, sat_en,
                output is_fixed, carry_out, negative, sign_flag, invalid);
  modport core (output op, opa, opb, fres, carry_in, sat_en,
                input is_fixed, carry_out, negative, sign_flag, invalid);
endinterface : pxa_alu_if

// file: logic/pxa_alu_eval.sv
`timescale 1ns/1ps
module pxa_alu_eval (
  pxa_alu_if.eval alu
);
  import pxa_pkg::*;
  logic [32:0] sum;
  logic [31:0] res;
  logic [31:0] mag_b;
  logic        nan_a;
  logic        nan_b;
  logic        inf_a;
  logic        inf_b;
  logic        ovf_a;
  logic        sgn_x;

  always_comb begin
    nan_a = (alu.opa[EXP_MSB:EXP_LSB] == EXP_ONES) && (alu.opa[EXP_LSB-1:0] != '0);
    nan_b = (alu.opb[EXP_MSB:EXP_LSB] == EXP_ONES) && (alu.opb[EXP_LSB-1:0] != '0);
    inf_a = (alu.opa[EXP_MSB:EXP_LSB] == EXP_ONES) && (alu.opa[EXP_LSB-1:0] == '0);
    inf_b = (alu.opb[EXP_MSB:EXP_LSB] == EXP_ONES) && (alu.opb[EXP_LSB-1:0] == '0);
    ovf_a = alu.opa[EXP_MSB:EXP_LSB] >= FIX_OVF_EXP;
    sgn_x = alu.opa[31] ^ alu.opb[31];
    mag_b = alu.opb[31] ? -alu.opb : alu.opb;
    sum   = '0;
    res   = alu.opa;
    unique case (alu.op)
      OP_ADD:  sum = {1'b0, alu.opa} + {1'b0, alu.opb};
      OP_SUB:  sum = {1'b0, alu.opa} + {1'b0, ~alu.opb} + 33'h1;
      OP_ADDC: sum = {1'b0, alu.opa} + {1'b0, alu.opb} + {32'h0, alu.carry_in};
      OP_SUBC: sum = {1'b0, alu.opa} + {1'b0, ~alu.opb} + {32'h0, alu.carry_in};
      OP_PASS: res = alu.opa;
      OP_MIN:  res = ($signed(alu.opa) < $signed(alu.opb)) ? alu.opa : alu.opb;
      OP_MAX:  res = ($signed(alu.opa) > $signed(alu.opb)) ? alu.opa : alu.opb;
      OP_COMP: res = alu.opa - alu.opb;
      OP_ABS:  res = alu.opa[31] ? -alu.opa : alu.opa;
      OP_OP_A: begin
        if ($signed(alu.opa) > $signed(mag_b)) begin
          res = mag_b;
        end else if ($signed(alu.opa) < $signed(-mag_b)) begin
          res = -mag_b;
        end
      end
      OP_FADD, OP_FSUB, OP_FABS, OP_FMANT, OP_FIX, OP_FPASS: res = alu.fres;
    endcase
    if (alu.op <= OP_SUBC) begin
      res = sum[31:0];
    end
    // Only the add family can carry; the other fixed ops leave sum at zero.
    alu.is_fixed  = alu.op <= OP_OP_A;
    alu.carry_out = sum[32];
    alu.negative  = res[31];
    alu.sign_flag = (alu.op inside {OP_ABS, OP_FABS, OP_FMANT}) && alu.opa[31];
    alu.invalid   = 1'b0;
    if (alu.op == OP_FADD) begin
      alu.invalid = nan_a || nan_b || (inf_a && inf_b && sgn_x);
    end else if (alu.op == OP_FSUB) begin
      alu.invalid = nan_a || nan_b || (inf_a && inf_b && !sgn_x);
    end else if (alu.op == OP_FIX) begin
      alu.invalid = nan_a || (!alu.sat_en && (inf_a || ovf_a));
    end else if (!alu.is_fixed) begin
      alu.invalid = nan_a;
    end
  end
endmodule : pxa_alu_eval

// file: logic/pxa_arith_status.sv
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
// How it works
// - Multiplier negative flag follows latest result sign.
// - Every multiplier operation refreshes that flag.
// - Every ALU operation refreshes the invalid flag.
// - Invalid also sets both sticky invalid bits.
// - NaN or bad infinity arithmetic is invalid.
// - Unsaturated float-to-fix overflow is invalid.
// - Unsaturated float-to-fix of infinity is invalid.
// - Absolute and mantissa ops record input sign.
// - Other ALU operations clear the sign flag.
// - Fixed ops record carry out of MSB.
// - Pass, min, max, compare, abs, op_a clear carry.
// - Carry flag feeds add and subtract with carry.
// - Every ALU operation records result negative.
module pxa_arith_status #(
  parameter int ADDR_W = 8
) (
  input  logic                clk_in,
  input  logic                rstn_in,
  input  logic [ADDR_W-1:0]   s_axi_awaddr_in,
  input  logic                s_axi_awvalid_in,
  output logic                s_axi_awready_out,
  input  logic [31:0]         s_axi_wdata_in,
  input  logic [3:0]          s_axi_wstrb_in,
  input  logic                s_axi_wvalid_in,
  output logic                s_axi_wready_out,
  output logic [1:0]          s_axi_bresp_out,
  output logic                s_axi_bvalid_out,
  input  logic                s_axi_bready_in,
  input  logic [ADDR_W-1:0]   s_axi_araddr_in,
  input  logic                s_axi_arvalid_in,
  output logic                s_axi_arready_out,
  output logic [31:0]         s_axi_rdata_out,
  output logic [1:0]          s_axi_rresp_out,
  output logic                s_axi_rvalid_out,
  input  logic                s_axi_rready_in,
  input  logic                alu_valid_in,
  input  pxa_pkg::pxa_op_e    alu_op_in,
  input  logic [31:0]         alu_opa_in,
  input  logic [31:0]         alu_opb_in,
  input  logic [31:0]         alu_fres_in,
  input  logic                mult_valid_in,
  input  logic [31:0]         mult_result_in,
  output logic [31:0]         arith_status_out,
  output logic                irq_out
);
  import pxa_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 8 and 32.");
  end

  typedef struct packed {
    logic [31:0]       stat;
    logic [31:0]       stkyx;
    logic [31:0]       stkyy;
    logic [31:0]       ctrl;
    logic [31:0]       irq_st;
    logic [31:0]       irq_mk;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic [ADDR_W-1:0] awaddr;
    logic [3:0]        wstrb;
    logic              aw_got;
    logic              w_got;
    logic              bvalid;
    logic              rvalid;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
  } pxa_state_s;

  localparam pxa_state_s RST_STATE = '{
    stat:   STATUS_RST,
    stkyx:  STKY_RST,
    stkyy:  STKY_RST,
    ctrl:   CTRL_RST,
    irq_st: IRQ_RST,
    irq_mk: IRQ_RST,
    default: '0
  };

  pxa_state_s        r;
  pxa_state_s        n;
  pxa_alu_if         alu ();
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              wr_go;
  logic              wr_stat;
  logic              rd_clr;
  logic [ADDR_W-1:0] wa;
  logic [31:0]       wd;
  logic [3:0]        ws;
  pxa_reg_e          wsel;
  pxa_reg_e          rsel;
  logic [31:0]       ev;

  function automatic pxa_reg_e pxa_dec(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w       = {a[ADDR_W-1:2], 2'b00};
    pxa_dec = R_NONE;
    if (w == ADDR_W'(OFS_STATUS)) pxa_dec = R_STATUS;
    if (w == ADDR_W'(OFS_STKYX))  pxa_dec = R_STKYX;
    if (w == ADDR_W'(OFS_STKYY))  pxa_dec = R_STKYY;
    if (w == ADDR_W'(OFS_CTRL))   pxa_dec = R_CTRL;
    if (w == ADDR_W'(OFS_IRQ_ST)) pxa_dec = R_IRQ_ST;
    if (w == ADDR_W'(OFS_IRQ_MK)) pxa_dec = R_IRQ_MK;
  endfunction : pxa_dec

  function automatic logic [31:0] pxa_merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0]  s,
    input logic [31:0] m
  );
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[8*i +: 8] = d[8*i +: 8];
      end
    end
    return v & m;
  endfunction : pxa_merge

  assign alu.op       = alu_op_in;
  assign alu.opa      = alu_opa_in;
  assign alu.opb      = alu_opb_in;
  assign alu.fres     = alu_fres_in;
  assign alu.carry_in = r.stat[ALU_CARRY_BIT];
  assign alu.sat_en   = r.ctrl[SAT_BIT];

  pxa_alu_eval u_eval (
    .alu (alu)
  );

  // Each channel refuses while a response is pending, so no write is lost.
  assign s_axi_awready_out = !r.aw_got && !r.bvalid;
  assign s_axi_wready_out  = !r.w_got && !r.bvalid;
  assign s_axi_arready_out = !r.rvalid;
  assign s_axi_bvalid_out  = r.bvalid;
  assign s_axi_bresp_out   = r.bresp;
  assign s_axi_rvalid_out  = r.rvalid;
  assign s_axi_rdata_out   = r.rdata;
  assign s_axi_rresp_out   = r.rresp;
  assign arith_status_out  = r.stat;
  assign irq_out           = |(r.irq_st & r.irq_mk);

  assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  assign w_hs  = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;

  always_comb begin
    n       = r;
    wa      = r.aw_got ? r.awaddr : s_axi_awaddr_in;
    wd      = r.w_got ? r.wdata : s_axi_wdata_in;
    ws      = r.w_got ? r.wstrb : s_axi_wstrb_in;
    wsel    = pxa_dec(wa);
    rsel    = pxa_dec(s_axi_araddr_in);
    wr_go   = (r.aw_got || aw_hs) && (r.w_got || w_hs);
    wr_stat = wr_go && (wsel == R_STATUS);
    rd_clr  = ar_hs && (rsel == R_IRQ_ST);
    ev      = '0;
    if (aw_hs) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr_in;
    end
    if (w_hs) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata_in;
      n.wstrb = s_axi_wstrb_in;
    end
    if (r.bvalid && s_axi_bready_in) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = (wsel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (wsel)
        R_STATUS: n.stat   = pxa_merge(r.stat, wd, ws, STATUS_MASK);
        R_STKYX:  n.stkyx  = pxa_merge(r.stkyx, wd, ws, STKY_MASK);
        R_STKYY:  n.stkyy  = pxa_merge(r.stkyy, wd, ws, STKY_MASK);
        R_CTRL:   n.ctrl   = pxa_merge(r.ctrl, wd, ws, CTRL_MASK);
        R_IRQ_MK: n.irq_mk = pxa_merge(r.irq_mk, wd, ws, IRQ_MASK);
        R_IRQ_ST, R_NONE: n.bresp = n.bresp;
      endcase
    end
    if (r.rvalid && s_axi_rready_in) begin
      n.rvalid = 1'b0;
    end
    if (ar_hs) begin
      n.rvalid = 1'b1;
      n.rresp  = (rsel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rsel)
        R_STATUS: n.rdata = r.stat;
        R_STKYX:  n.rdata = r.stkyx;
        R_STKYY:  n.rdata = r.stkyy;
        R_CTRL:   n.rdata = r.ctrl;
        R_IRQ_ST: n.rdata = r.irq_st;
        R_IRQ_MK: n.rdata = r.irq_mk;
        R_NONE:   n.rdata = '0;
      endcase
    end
    // Core updates follow the software write so a flag event is never lost.
    if (mult_valid_in) begin
      n.stat[MULT_NEG_BIT] = mult_result_in[31];
    end
    if (alu_valid_in) begin
      n.stat[ALU_INV_BIT]  = alu.invalid;
      n.stat[ALU_SIGN_BIT] = alu.sign_flag;
      n.stat[ALU_NEG_BIT]  = alu.negative;
      if (alu.is_fixed) begin
        n.stat[ALU_CARRY_BIT] = alu.carry_out;
      end
      if (alu.invalid) begin
        n.stkyx[INV_STICKY_BIT] = 1'b1;
        n.stkyy[INV_STICKY_BIT] = 1'b1;
      end
      ev[IRQ_INV_BIT]   = alu.invalid;
      ev[IRQ_CARRY_BIT] = alu.is_fixed && alu.carry_out;
    end
    n.irq_st = ((rd_clr ? '0 : r.irq_st) | ev) & IRQ_MASK;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= RST_STATE;
    end else begin
      r <= n;
    end
  end

  logic [32:0] chk_sum;
  logic        chk_inf;
  logic        chk_nan;
  assign chk_sum = {1'b0, alu_opa_in} + {1'b0, alu_opb_in};
  assign chk_inf = (alu_opa_in[EXP_MSB:EXP_LSB] == EXP_ONES)
                && (alu_opa_in[EXP_LSB-1:0] == '0);
  assign chk_nan = (alu_opa_in[EXP_MSB:EXP_LSB] == EXP_ONES)
                && (alu_opa_in[EXP_LSB-1:0] != '0);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  AST_MULT_NEG_SIGN: assert property (
    mult_valid_in |=> r.stat[MULT_NEG_BIT] == $past(mult_result_in[31]))
    else $error("Multiplier negative flag does not follow result.");
  AST_MULT_NEG_HOLD: assert property (
    !mult_valid_in && !wr_stat |=> $stable(r.stat[MULT_NEG_BIT]))
    else $error("Multiplier negative flag changed without an operation.");
  AST_INV_FIXED: assert property (
    alu_valid_in && alu_op_in <= OP_OP_A |=> !r.stat[ALU_INV_BIT])
    else $error("Fixed operation left the invalid flag set.");
  AST_INV_STICKY_BOTH: assert property (
    alu_valid_in && alu.invalid |=> r.stkyx[INV_STICKY_BIT] && r.stkyy[INV_STICKY_BIT]
    && (irq_out || !r.irq_mk[IRQ_INV_BIT]))
    else $error("Sticky invalid bits not set with invalid flag.");
  AST_INV_SUB_INF: assert property (
    alu_valid_in && alu_op_in == OP_FSUB && chk_inf && alu_opb_in == alu_opa_in
    |=> r.stat[ALU_INV_BIT])
    else $error("Like-signed infinity subtract not flagged invalid.");
  AST_INV_OVF: assert property (
    alu_valid_in && alu_op_in == OP_FIX && !chk_nan
    && alu_opa_in[EXP_MSB:EXP_LSB] >= FIX_OVF_EXP
    |=> r.stat[ALU_INV_BIT] == !$past(r.ctrl[SAT_BIT]))
    else $error("Conversion overflow invalid flag wrong for saturation mode.");
  AST_INV_CVT_INF: assert property (
    alu_valid_in && alu_op_in == OP_FIX && chk_inf && !r.ctrl[SAT_BIT]
    ##1 !alu_valid_in && !wr_stat |=> r.stat[ALU_INV_BIT])
    else $error("Infinity conversion not flagged invalid.");
  AST_SIGN_ABS: assert property (
    alu_valid_in && alu_op_in inside {OP_ABS, OP_FMANT}
    |=> r.stat[ALU_SIGN_BIT] == $past(alu_opa_in[31]))
    else $error("Sign flag does not show the input sign.");
  AST_SIGN_CLR: assert property (
    alu_valid_in && !(alu_op_in inside {OP_ABS, OP_FABS, OP_FMANT}) |=> !r.stat[ALU_SIGN_BIT])
    else $error("Sign flag not cleared by another operation.");
  AST_CARRY_ADD: assert property (
    alu_valid_in && alu_op_in == OP_ADD |=> r.stat[ALU_CARRY_BIT] == $past(chk_sum[32]))
    else $error("Carry flag does not match the add carry.");
  AST_CARRY_CLR: assert property (
    alu_valid_in && alu_op_in inside {[OP_PASS:OP_OP_A]} |=> !r.stat[ALU_CARRY_BIT])
    else $error("Carry flag not cleared by a logic operation.");
  AST_CARRY_CHAIN: assert property (
    alu_valid_in && alu_op_in == OP_ADDC && alu_opa_in == 32'h0000_0000
    && alu_opb_in == 32'hFFFF_FFFF
    |=> r.stat[ALU_CARRY_BIT] == $past(r.stat[ALU_CARRY_BIT])
    && r.stat[ALU_NEG_BIT] == !$past(r.stat[ALU_CARRY_BIT]))
    else $error("Add with carry ignored the carry flag.");
  AST_NEG_PASS: assert property (
    alu_valid_in && alu_op_in inside {OP_PASS, OP_FPASS}
    |=> r.stat[ALU_NEG_BIT] == $past(alu_op_in == OP_PASS ? alu_opa_in[31] : alu_fres_in[31]))
    else $error("Negative flag does not show result sign.");
  // The add, min and max arms each get their own check and the float add, subtract and fix arms share one, so a slip in those arms cannot hide.
  AST_NEG_ADD: assert property (
    alu_valid_in && alu_op_in == OP_ADD |=> r.stat[ALU_NEG_BIT] == $past(chk_sum[31]))
    else $error("Negative flag does not match the add result.");
  AST_NEG_MIN: assert property (
    alu_valid_in && alu_op_in == OP_MIN
    |=> r.stat[ALU_NEG_BIT] == $past(alu_opa_in[31] || alu_opb_in[31]))
    else $error("Negative flag does not match the minimum result.");
  AST_NEG_MAX: assert property (
    alu_valid_in && alu_op_in == OP_MAX
    |=> r.stat[ALU_NEG_BIT] == $past(alu_opa_in[31] && alu_opb_in[31]))
    else $error("Negative flag does not match the maximum result.");
  AST_NEG_FLOAT: assert property (
    alu_valid_in && alu_op_in inside {OP_FADD, OP_FSUB, OP_FIX}
    |=> r.stat[ALU_NEG_BIT] == $past(alu_fres_in[31]))
    else $error("Negative flag does not follow the float result.");
  AST_INV_NAN: assert property (
    alu_valid_in && alu_op_in > OP_OP_A && chk_nan |=> r.stat[ALU_INV_BIT])
    else $error("Not-a-number operand not flagged invalid.");
  AST_INV_ADD_INF: assert property (
    alu_valid_in && alu_op_in == OP_FADD && chk_inf
    && alu_opb_in == {~alu_opa_in[31], alu_opa_in[30:0]} |=> r.stat[ALU_INV_BIT])
    else $error("Opposite-signed infinity add not flagged invalid.");
  AST_INV_SUB_OK: assert property (
    alu_valid_in && alu_op_in == OP_FSUB && chk_inf
    && alu_opb_in == {~alu_opa_in[31], alu_opa_in[30:0]} |=> !r.stat[ALU_INV_BIT])
    else $error("Opposite-signed infinity subtract flagged invalid.");
  AST_INV_FINITE: assert property (
    alu_valid_in && alu_op_in == OP_FADD && alu_opa_in[EXP_MSB:EXP_LSB] != EXP_ONES
    && alu_opb_in[EXP_MSB:EXP_LSB] != EXP_ONES |=> !r.stat[ALU_INV_BIT])
    else $error("Finite float add flagged invalid.");
  AST_INV_CVT_SAT: assert property (
    alu_valid_in && alu_op_in == OP_FIX && chk_inf && r.ctrl[SAT_BIT]
    |=> !r.stat[ALU_INV_BIT])
    else $error("Saturated infinity conversion flagged invalid.");
  AST_SIGN_FABS: assert property (
    alu_valid_in && alu_op_in == OP_FABS |=> r.stat[ALU_SIGN_BIT] == $past(alu_opa_in[31]))
    else $error("Float absolute value sign flag wrong.");
  AST_CARRY_SUB: assert property (
    alu_valid_in && alu_op_in == OP_SUB
    |=> r.stat[ALU_CARRY_BIT] == $past(alu_opa_in >= alu_opb_in))
    else $error("Carry flag does not match the subtract carry.");
  // Float operations keep the carry, so only a software write may move it then.
  AST_CARRY_FLOAT_KEEP: assert property (
    alu_valid_in && alu_op_in > OP_OP_A && !wr_stat |=> $stable(r.stat[ALU_CARRY_BIT]))
    else $error("Float operation changed the carry flag.");
  AST_STKY_X_HOLD: assert property (
    r.stkyx[INV_STICKY_BIT] && !(wr_go && wsel == R_STKYX) |=> r.stkyx[INV_STICKY_BIT])
    else $error("X sticky invalid bit dropped without a write.");
  AST_STKY_Y_HOLD: assert property (
    r.stkyy[INV_STICKY_BIT] && !(wr_go && wsel == R_STKYY) |=> r.stkyy[INV_STICKY_BIT])
    else $error("Y sticky invalid bit dropped without a write.");
endmodule : pxa_arith_status

// file: verif/pxa_arith_status_tb.sv
`timescale 1ns/1ps
module pxa_arith_status_tb;
  import pxa_pkg::*;
  logic        clk_in;
  logic        rstn_in;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        rready;
  logic        alu_valid;
  pxa_op_e     alu_op;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] fres;
  logic        mult_valid;
  logic [31:0] mult_res;
  logic        s_axi_awready_out;
  logic        s_axi_wready_out;
  logic [1:0]  s_axi_bresp_out;
  logic        s_axi_bvalid_out;
  logic        s_axi_arready_out;
  logic [31:0] s_axi_rdata_out;
  logic [1:0]  s_axi_rresp_out;
  logic        s_axi_rvalid_out;
  logic [31:0] arith_status_out;
  logic        irq_out;
  int          miscompares;
  int          samples_checked;
  logic [7:0]  offs [6] = '{OFS_STATUS, OFS_STKYX, OFS_STKYY, OFS_CTRL, OFS_IRQ_ST, OFS_IRQ_MK};
  logic [31:0] mres [4] = '{32'h8000_0000, 32'h0000_0001, 32'hBF80_0000, 32'h3F80_0000};
  pxa_op_e     fx_op [16] = '{OP_ADD, OP_ADDC, OP_ADDC, OP_ADDC, OP_SUB, OP_SUBC, OP_SUB, OP_SUBC,
    OP_ADD, OP_ABS, OP_ADD, OP_FMANT, OP_FABS, OP_FPASS, OP_FADD, OP_ABS};
  logic [31:0] fx_a [16] = '{32'hFFFF_FFFF, 0, 0, 0, 5, 3, 3, 5, 32'h7FFF_FFFF, 32'hFFFF_FFF0,
    32'hFFFF_FFFF, 32'hBF80_0000, 32'h3F80_0000, 32'h3F80_0000, 32'h3F80_0000, 5};
  logic [31:0] fx_b [16] = '{1, 32'hFFFF_FFFF, 0, 32'hFFFF_FFFF, 3, 5, 5, 3, 1, 0, 1, 0, 0, 0,
    32'h3F80_0000, 0};
  logic [31:0] fx_f [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 32'h8000_0000, 0, 0};
  logic [7:0]  fx_e [16] = '{8'h08, 8'h08, 8'h00, 8'h04, 8'h08, 8'h04, 8'h04, 8'h08, 8'h04,
    8'h10, 8'h08, 8'h18, 8'h08, 8'h0C, 8'h08, 8'h00};
  pxa_op_e     iv_op [10] = '{OP_FADD, OP_FADD, OP_FADD, OP_FSUB, OP_FSUB, OP_FIX, OP_FIX, OP_FIX,
    OP_FIX, OP_FIX};
  logic [31:0] iv_a [10] = '{32'h7FC0_0000, 32'h7F80_0000, 32'h7F80_0000, 32'h7F80_0000,
    32'h7F80_0000, 32'h4F00_0000, 32'h4F00_0000, 32'h4EFF_FFFF, 32'h7F80_0000, 32'h7F80_0000};
  logic [31:0] iv_b [10] = '{32'h3F80_0000, 32'hFF80_0000, 32'h7F80_0000, 32'h7F80_0000,
    32'hFF80_0000, 0, 0, 0, 0, 0};
  logic        iv_s [10] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 1};
  logic        iv_i [10] = '{1, 1, 0, 1, 0, 1, 0, 0, 1, 0};

  pxa_arith_status #(.ADDR_W(8)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(rready),
    .alu_valid_in(alu_valid), .alu_op_in(alu_op), .alu_opa_in(opa), .alu_opb_in(opb),
    .alu_fres_in(fres), .mult_valid_in(mult_valid), .mult_result_in(mult_res),
    .arith_status_out(arith_status_out), .irq_out(irq_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask : chk

  // A hung handshake is cut short here so the run always reaches its verdict.
  task automatic tick(inout int n);
    @(posedge clk_in);
    n++;
    if (n > 40) begin
      $display("bus handshake timed out");
      miscompares++;
      close_out();
    end
  endtask : tick

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                        input string name);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      tick(n);
      if (!aw_ok && s_axi_awready_out === 1'b1) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && s_axi_wready_out === 1'b1) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do tick(n); while (s_axi_bvalid_out !== 1'b1);
    bready <= 1'b0;
    chk(name, {30'h0, s_axi_bresp_out}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                        input string name);
    int n;
    n = 0;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do tick(n); while (s_axi_arready_out !== 1'b1);
    arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid_out !== 1'b1);
    rready <= 1'b0;
    chk(name, s_axi_rdata_out, ed);
    chk(name, {30'h0, s_axi_rresp_out}, {30'h0, er});
  endtask : axi_rd

  task automatic alu(input pxa_op_e op, input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] f);
    @(posedge clk_in);
    alu_valid <= 1'b1;
    alu_op <= op;
    opa <= a;
    opb <= b;
    fres <= f;
    @(posedge clk_in);
    alu_valid <= 1'b0;
    @(negedge clk_in);
  endtask : alu

  initial begin
    {rstn_in, awvalid, wvalid, bready, arvalid, rready, alu_valid, mult_valid} = '0;
    {awaddr, araddr, wdata, opa, opb, fres, mult_res} = '0;
    wstrb = 4'hF;
    alu_op = OP_ADD;
    miscompares = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 6; i++) axi_rd(offs[i], 32'h0000_0000, RESP_OKAY, "reset value");
    axi_rd(8'h18, 32'h0000_0000, RESP_SLVERR, "unmapped read");
    axi_wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR, "unmapped write");
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      mult_valid <= 1'b1;
      mult_res <= mres[i];
      @(posedge clk_in);
      mult_valid <= 1'b0;
      @(negedge clk_in);
      chk("mult negative", arith_status_out, (i % 2 == 0) ? 32'h0000_0040 : 32'h0000_0000);
    end
    $display("test multiplier flag done");
    for (int i = 0; i < 16; i++) begin
      alu(fx_op[i], fx_a[i], fx_b[i], fx_f[i]);
      chk("flag table", arith_status_out, {24'h0, fx_e[i]});
    end
    chk("masked irq", {31'h0, irq_out}, 32'h0000_0000);
    // Each op is preceded by a carrying add, so a kept carry would show.
    for (int k = 4; k <= 9; k++) begin
      alu(OP_ADD, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0000);
      alu(pxa_op_e'(4'(k)), 32'h0000_0005, 32'h0000_0003, 32'h0000_0000);
      chk("carry clear", arith_status_out, 32'h0000_0000);
    end
    axi_rd(OFS_IRQ_ST, 32'h0000_0002, RESP_OKAY, "irq status");
    axi_rd(OFS_IRQ_ST, 32'h0000_0000, RESP_OKAY, "irq cleared");
    axi_wr(OFS_IRQ_MK, 32'h0000_0001, RESP_OKAY, "mask write");
    $display("test fixed flags done");
    for (int i = 0; i < 10; i++) begin
      axi_wr(OFS_CTRL, {31'h0, iv_s[i]}, RESP_OKAY, "ctrl write");
      alu(iv_op[i], iv_a[i], iv_b[i], 32'h0000_0000);
      chk("invalid flag", arith_status_out, {26'h0, iv_i[i], 5'h0});
    end
    chk("irq raised", {31'h0, irq_out}, 32'h0000_0001);
    axi_rd(OFS_STKYX, 32'h0000_0004, RESP_OKAY, "x sticky");
    axi_rd(OFS_STKYY, 32'h0000_0004, RESP_OKAY, "y sticky");
    axi_rd(OFS_IRQ_ST, 32'h0000_0001, RESP_OKAY, "irq status");
    chk("irq dropped", {31'h0, irq_out}, 32'h0000_0000);
    $display("test invalid flags done");
    axi_wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY, "status write");
    axi_rd(OFS_STATUS, STATUS_MASK, RESP_OKAY, "status readback");
    axi_wr(OFS_IRQ_ST, 32'h0000_0003, RESP_OKAY, "irq status write");
    axi_rd(OFS_IRQ_ST, 32'h0000_0000, RESP_OKAY, "irq status kept");
    $display("test software access done");
    close_out();
  end
endmodule : pxa_arith_status_tb
